// ---- esf_cfg.svh ----
// Register offsets, field positions, reset values and capacities of the memory block.
`ifndef ESF_CFG_SVH
`define ESF_CFG_SVH

`define ESF_OFF_CTRL 8'h00
`define ESF_OFF_DEPTH 8'h04
`define ESF_OFF_AE_THR 8'h08
`define ESF_OFF_AF_THR 8'h0c
`define ESF_OFF_STATUS 8'h10
`define ESF_OFF_IRQ_STS 8'h14
`define ESF_OFF_IRQ_EN 8'h18
`define ESF_OFF_IRQ_CLR 8'h1c

`define ESF_CTRL_WWID 0
`define ESF_CTRL_RWID 3
`define ESF_CTRL_FIFO 6
`define ESF_STAT_EMPTY 0
`define ESF_STAT_FULL 1
`define ESF_STAT_AE 2
`define ESF_STAT_AF 3
`define ESF_STAT_COUNT 16

`define ESF_IRQ_WR_REJ 0
`define ESF_IRQ_RD_REJ 1
`define ESF_IRQ_FULL 2
`define ESF_IRQ_EMPTY 3

`define ESF_BITS_WIDE 13'h1200
`define ESF_BITS_NARROW 13'h1000
`define ESF_RST_CTRL 7'h00
`define ESF_RST_DEPTH 13'h1200
`define ESF_RST_AE_THR 13'h0000
`define ESF_RST_AF_THR 13'h1200
`define ESF_RST_IRQ_EN 4'h0

`endif

// ---- esf_pkg.sv ----
// Types and shared width arithmetic of the memory block.
package esf_pkg;

	typedef enum logic [2:0] {
		W1 = 3'h0,
		W2 = 3'h1,
		W4 = 3'h2,
		W9 = 3'h3,
		W18 = 3'h4
	} esf_width_e;

	typedef struct packed {
		logic [11:0] ptr;
	} esf_ptr_s;

	typedef struct packed {
		logic [17:0] rdata;
	} esf_ram_s;

	typedef struct packed {
		esf_width_e wwid;
		esf_width_e rwid;
		logic fifo_en;
		logic [12:0] depth;
		logic [12:0] ae_thr;
		logic [12:0] af_thr;
		logic [3:0] sts;
		logic [3:0] ien;
		logic [12:0] count;
		logic empty;
		logic full;
		logic ae;
		logic af;
		logic rd_valid;
		logic irq;
		logic [31:0] hrdata;
		logic hready;
		logic dp_wr;
		logic [7:0] dp_addr;
	} esf_top_s;

	// Codes above the widest organization fall back to it.
	function automatic esf_width_e to_wid(input logic [2:0] code);
		begin
			to_wid = (code > 3'h4) ? W18 : esf_width_e'(code);
		end
	endfunction

	function automatic logic [12:0] width_bits(input esf_width_e w);
		begin
			case (w)
				W1: width_bits = 13'h0001;
				W2: width_bits = 13'h0002;
				W4: width_bits = 13'h0004;
				W9: width_bits = 13'h0009;
				default: width_bits = 13'h0012;
			endcase
		end
	endfunction

	function automatic logic [11:0] wrap_mask(input esf_width_e w);
		begin
			case (w)
				W1: wrap_mask = 12'hfff;
				W2: wrap_mask = 12'h7ff;
				W4: wrap_mask = 12'h3ff;
				W9: wrap_mask = 12'h1ff;
				default: wrap_mask = 12'h0ff;
			endcase
		end
	endfunction

endpackage

// ---- esf_ptr.sv ----
// Wrapping address counter for one port of the FIFO control unit.
`timescale 1ns/1ps
module esf_ptr (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// Control
	input wire logic clr_i,
	input wire logic adv_i,
	input wire esf_pkg::esf_width_e wid_i,
	// Address
	output logic [11:0] ptr_o
);
	esf_pkg::esf_ptr_s q;
	esf_pkg::esf_ptr_s next_q;

	always_comb begin
		next_q = q;
		if (clr_i) begin
			next_q.ptr = 12'h000;
		end else if (adv_i) begin
			next_q.ptr = (q.ptr + 12'h001) & esf_pkg::wrap_mask(wid_i);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign ptr_o = q.ptr;
endmodule

// ---- esf_ram.sv ----
// Variable-aspect-ratio storage array with separate write and read ports.
`timescale 1ns/1ps
module esf_ram (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// Write port
	input wire logic we_i,
	input wire logic [11:0] waddr_i,
	input wire esf_pkg::esf_width_e wwid_i,
	input wire logic [17:0] wdata_i,
	// Read port
	input wire logic re_i,
	input wire logic [11:0] raddr_i,
	input wire esf_pkg::esf_width_e rwid_i,
	output logic [17:0] rdata_o
);
	// Narrow organizations use the eight low bits of each nine-bit word.
	logic [8:0] mem [512];
	esf_pkg::esf_ram_s q;
	esf_pkg::esf_ram_s next_q;
	logic [8:0] widx;
	logic [8:0] wmask;
	logic [8:0] wlane;
	logic [8:0] ridx;

	function automatic logic [8:0] word_idx(input esf_pkg::esf_width_e w, input logic [11:0] a);
		begin
			case (w)
				esf_pkg::W1: word_idx = a[11:3];
				esf_pkg::W2: word_idx = a[10:2];
				esf_pkg::W4: word_idx = a[9:1];
				esf_pkg::W9: word_idx = a[8:0];
				default: word_idx = {a[7:0], 1'b0};
			endcase
		end
	endfunction

	assign widx = word_idx(wwid_i, waddr_i);
	assign ridx = word_idx(rwid_i, raddr_i);

	always_comb begin
		wmask = 9'h1ff;
		wlane = wdata_i[8:0];
		case (wwid_i)
			esf_pkg::W1: begin
				wmask = 9'h001 << waddr_i[2:0];
				wlane = {8'h00, wdata_i[0]} << waddr_i[2:0];
			end
			esf_pkg::W2: begin
				wmask = 9'h003 << {waddr_i[1:0], 1'b0};
				wlane = {7'h00, wdata_i[1:0]} << {waddr_i[1:0], 1'b0};
			end
			esf_pkg::W4: begin
				wmask = 9'h00f << {waddr_i[0], 2'b00};
				wlane = {5'h00, wdata_i[3:0]} << {waddr_i[0], 2'b00};
			end
			default: begin
				wmask = 9'h1ff;
				wlane = wdata_i[8:0];
			end
		endcase
	end

	// bit lanes let ports of unequal width share words.
	always_ff @(posedge mclk_i) begin
		if (we_i) begin
			mem[widx] <= (mem[widx] & ~wmask) | (wlane & wmask);
			if (wwid_i == esf_pkg::W18) begin
				mem[widx | 9'h001] <= wdata_i[17:9];
			end
		end
	end

	always_comb begin
		next_q = q;
		if (re_i) begin
			case (rwid_i)
				esf_pkg::W1: next_q.rdata = {17'h00000, mem[ridx][raddr_i[2:0]]};
				esf_pkg::W2: next_q.rdata = {16'h0000, mem[ridx][{raddr_i[1:0], 1'b0} +: 2]};
				esf_pkg::W4: next_q.rdata = {14'h0000, mem[ridx][{raddr_i[0], 2'b00} +: 4]};
				esf_pkg::W9: next_q.rdata = {9'h000, mem[ridx]};
				default: next_q.rdata = {mem[ridx | 9'h001], mem[ridx]};
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign rdata_o = q.rdata;
endmodule

// ---- esf_top.sv ----
// Embedded memory block with FIFO control unit, test preload and AHB-Lite registers.
//
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "esf_cfg.svh"
module esf_top (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Fabric write port
	input wire logic wr_en_i,
	input wire logic [11:0] wr_addr_i,
	input wire logic [17:0] wr_data_i,
	// Fabric read port
	input wire logic rd_en_i,
	input wire logic [11:0] rd_addr_i,
	output logic [17:0] rd_data_o,
	output logic rd_valid_o,
	// FIFO flags
	output logic empty_o,
	output logic full_o,
	output logic nearly_drained_flag_o,
	output logic nearly_filled_flag_o,
	// Test preload port
	input wire logic tst_we_i,
	input wire logic [7:0] tst_addr_i,
	input wire logic [17:0] tst_data_i,
	// Interrupt
	output logic irq_o
);
	esf_pkg::esf_top_s q;
	esf_pkg::esf_top_s next_q;
	logic [11:0] wptr;
	logic [11:0] rptr;
	logic [12:0] wbits;
	logic [12:0] rbits;
	logic [12:0] limit;
	logic wr_ok;
	logic rd_ok;
	logic ctrl_wr;
	logic addr_ph;
	logic [3:0] ev;
	logic ram_we;
	logic [11:0] ram_waddr;
	esf_pkg::esf_width_e ram_wwid;
	logic [17:0] ram_wdata;
	logic [11:0] ram_raddr;

	assign wbits = esf_pkg::width_bits(q.wwid);
	assign rbits = esf_pkg::width_bits(q.rwid);
	assign addr_ph = hsel_i && hready_i && htrans_i[1];
	assign ctrl_wr = q.dp_wr && (q.dp_addr == `ESF_OFF_CTRL);

	// capacity is 4608 bits when the write port uses nine- or 18-bit words, else 4096.
	// the programmed depth caps the occupancy below that.
	always_comb begin
		limit = (q.wwid >= esf_pkg::W9) ? `ESF_BITS_WIDE : `ESF_BITS_NARROW;
		if (q.depth < limit) begin
			limit = q.depth;
		end
	end

	// a write into a full FIFO or a read from a short one is refused.
	always_comb begin
		wr_ok = wr_en_i && !tst_we_i && !ctrl_wr;
		rd_ok = rd_en_i && !ctrl_wr;
		if (q.fifo_en) begin
			wr_ok = wr_ok && ((q.count + wbits) <= limit);
			rd_ok = rd_ok && (q.count >= rbits);
		end
	end

	// one counter per port produces the FIFO addresses.
	esf_ptr u_wptr (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.clr_i(ctrl_wr),
		.adv_i(q.fifo_en && wr_ok),
		.wid_i(q.wwid),
		.ptr_o(wptr)
	);

	esf_ptr u_rptr (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.clr_i(ctrl_wr),
		.adv_i(q.fifo_en && rd_ok),
		.wid_i(q.rwid),
		.ptr_o(rptr)
	);

	// the test port takes the write port in the 18-bit shape and wins over fabric.
	always_comb begin
		ram_we = tst_we_i || wr_ok;
		ram_waddr = q.fifo_en ? wptr : wr_addr_i;
		ram_wwid = q.wwid;
		ram_wdata = wr_data_i;
		if (tst_we_i) begin
			ram_waddr = {4'h0, tst_addr_i};
			ram_wwid = esf_pkg::W18;
			ram_wdata = tst_data_i;
		end
		ram_raddr = q.fifo_en ? rptr : rd_addr_i;
	end

	// each port is shaped by its own width code.
	esf_ram u_ram (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.we_i(ram_we),
		.waddr_i(ram_waddr),
		.wwid_i(ram_wwid),
		.wdata_i(ram_wdata),
		.re_i(rd_ok),
		.raddr_i(ram_raddr),
		.rwid_i(q.rwid),
		.rdata_o(rd_data_o)
	);

	always_comb begin
		next_q = q;
		next_q.hready = 1'b1;
		next_q.rd_valid = rd_ok;
		// occupancy is kept in bits so unequal port widths stay consistent.
		if (q.fifo_en) begin
			next_q.count = q.count + (wr_ok ? wbits : 13'h0000) - (rd_ok ? rbits : 13'h0000);
		end
		// Register writes land in the data phase.
		if (q.dp_wr) begin
			case (q.dp_addr)
				`ESF_OFF_CTRL: begin
					next_q.wwid = esf_pkg::to_wid(hwdata_i[`ESF_CTRL_WWID +: 3]);
					next_q.rwid = esf_pkg::to_wid(hwdata_i[`ESF_CTRL_RWID +: 3]);
					next_q.fifo_en = hwdata_i[`ESF_CTRL_FIFO];
					next_q.count = 13'h0000;
				end
				`ESF_OFF_DEPTH: next_q.depth = hwdata_i[12:0];
				`ESF_OFF_AE_THR: next_q.ae_thr = hwdata_i[12:0];
				`ESF_OFF_AF_THR: next_q.af_thr = hwdata_i[12:0];
				`ESF_OFF_IRQ_EN: next_q.ien = hwdata_i[3:0];
				default: next_q.count = next_q.count;
			endcase
		end
		// empty holds no bits, full has no room for one more write word.
		next_q.empty = !next_q.fifo_en || (next_q.count == 13'h0000);
		next_q.full = next_q.fifo_en && ((next_q.count + esf_pkg::width_bits(next_q.wwid)) >
			((next_q.wwid >= esf_pkg::W9) ?
			((next_q.depth < `ESF_BITS_WIDE) ? next_q.depth : `ESF_BITS_WIDE) :
			((next_q.depth < `ESF_BITS_NARROW) ? next_q.depth : `ESF_BITS_NARROW)));
		// almost flags compare occupancy with the thresholds.
		next_q.ae = next_q.fifo_en && (next_q.count <= next_q.ae_thr);
		next_q.af = next_q.fifo_en && (next_q.count >= next_q.af_thr);
		ev = 4'h0;
		ev[`ESF_IRQ_WR_REJ] = q.fifo_en && wr_en_i && !tst_we_i && !ctrl_wr && !wr_ok;
		ev[`ESF_IRQ_RD_REJ] = q.fifo_en && rd_en_i && !ctrl_wr && !rd_ok;
		ev[`ESF_IRQ_FULL] = next_q.full && !q.full;
		ev[`ESF_IRQ_EMPTY] = next_q.fifo_en && next_q.empty && !q.empty;
		// A new event wins over a clear in the same cycle.
		if (q.dp_wr && (q.dp_addr == `ESF_OFF_IRQ_CLR)) begin
			next_q.sts = q.sts & ~hwdata_i[3:0];
		end
		next_q.sts = next_q.sts | ev;
		next_q.irq = |(next_q.sts & next_q.ien);
		// Read data is prepared in the address phase so the slave never waits.
		next_q.dp_wr = addr_ph && hwrite_i;
		next_q.dp_addr = haddr_i[7:0];
		next_q.hrdata = 32'h00000000;
		if (addr_ph && !hwrite_i) begin
			case (haddr_i[7:0])
				`ESF_OFF_CTRL: begin
					next_q.hrdata[`ESF_CTRL_WWID +: 3] = next_q.wwid;
					next_q.hrdata[`ESF_CTRL_RWID +: 3] = next_q.rwid;
					next_q.hrdata[`ESF_CTRL_FIFO] = next_q.fifo_en;
				end
				`ESF_OFF_DEPTH: next_q.hrdata[12:0] = next_q.depth;
				`ESF_OFF_AE_THR: next_q.hrdata[12:0] = next_q.ae_thr;
				`ESF_OFF_AF_THR: next_q.hrdata[12:0] = next_q.af_thr;
				`ESF_OFF_STATUS: begin
					next_q.hrdata[`ESF_STAT_EMPTY] = next_q.empty;
					next_q.hrdata[`ESF_STAT_FULL] = next_q.full;
					next_q.hrdata[`ESF_STAT_AE] = next_q.ae;
					next_q.hrdata[`ESF_STAT_AF] = next_q.af;
					next_q.hrdata[`ESF_STAT_COUNT +: 13] = next_q.count;
				end
				`ESF_OFF_IRQ_STS: next_q.hrdata[3:0] = next_q.sts;
				`ESF_OFF_IRQ_EN: next_q.hrdata[3:0] = next_q.ien;
				default: next_q.hrdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			q <= '0;
			q.wwid <= esf_pkg::to_wid(3'(`ESF_RST_CTRL >> `ESF_CTRL_WWID));
			q.rwid <= esf_pkg::to_wid(3'(`ESF_RST_CTRL >> `ESF_CTRL_RWID));
			q.depth <= `ESF_RST_DEPTH;
			q.ae_thr <= `ESF_RST_AE_THR;
			q.af_thr <= `ESF_RST_AF_THR;
			q.ien <= `ESF_RST_IRQ_EN;
			q.empty <= 1'b1;
			q.hready <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	// flags and data leave straight from flops so blocks cascade cleanly.
	assign hrdata_o = q.hrdata;
	assign hreadyout_o = q.hready;
	assign hresp_o = 1'b0;
	assign rd_valid_o = q.rd_valid;
	assign empty_o = q.empty;
	assign full_o = q.full;
	assign nearly_drained_flag_o = q.ae;
	assign nearly_filled_flag_o = q.af;
	assign irq_o = q.irq;

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (reset_i);

	a_full_write_held: assert property (
		(q.fifo_en && full_o && wr_en_i && !rd_en_i && !q.dp_wr) |=> ($stable(q.count) && $stable(wptr))
	) else $error("write into full FIFO changed state");
	a_empty_read_held: assert property (
		(q.fifo_en && empty_o && rd_en_i && !wr_en_i && !q.dp_wr) |=> (!rd_valid_o && $stable(rptr))
	) else $error("read from empty FIFO changed state");
	a_empty_flag_count: assert property (
		q.fifo_en |-> (empty_o == (q.count == 13'h0000))
	) else $error("empty flag disagrees with occupancy");
	a_drain_flag_thr: assert property (
		q.fifo_en |-> (nearly_drained_flag_o == (q.count <= q.ae_thr))
	) else $error("nearly drained flag wrong");
	a_fill_flag_thr: assert property (
		q.fifo_en |-> (nearly_filled_flag_o == (q.count >= q.af_thr))
	) else $error("nearly filled flag wrong");
	a_wptr_step: assert property (
		(q.fifo_en && wr_ok && !ctrl_wr && q.wwid == esf_pkg::W4) |=>
			(wptr == (($past(wptr) + 12'h001) & 12'h3ff))
	) else $error("write pointer did not step");
	a_count_cap: assert property (
		q.count <= `ESF_BITS_WIDE
	) else $error("occupancy above capacity");
	a_read_valid: assert property (
		(q.fifo_en && rd_ok) |=> rd_valid_o ##1 (rd_valid_o == $past(rd_ok))
	) else $error("accepted read produced no data");
	a_preload_only: assert property (
		(q.fifo_en && tst_we_i && !rd_en_i && !q.dp_wr) |=> $stable(q.count)
	) else $error("preload disturbed FIFO occupancy");
	a_mixed_count: assert property (
		(q.fifo_en && wr_ok && !rd_ok && !q.dp_wr) |=> (q.count == $past(q.count) + $past(wbits))
	) else $error("occupancy did not grow by write width");
	// Full-flag, read-pointer, refusal, clearing and plain-memory checks, some of which a quiet FIFO run seldom reaches.
	a_full_flag_room: assert property (
		q.fifo_en |-> (full_o == ((q.count + wbits) > limit))
	) else $error("full flag disagrees with free room");
	a_wr_rej_sticky: assert property (
		(q.fifo_en && wr_en_i && !tst_we_i && !ctrl_wr && !wr_ok) |=> q.sts[`ESF_IRQ_WR_REJ]
	) else $error("refused write left no status bit");
	a_rptr_step: assert property (
		(q.fifo_en && rd_ok && !ctrl_wr && q.rwid == esf_pkg::W1) |=>
			(rptr == (($past(rptr) + 12'h001) & 12'hfff))
	) else $error("read pointer did not step");
	a_read_refused: assert property (
		(q.fifo_en && rd_en_i && !rd_ok && !wr_ok && !q.dp_wr) |=>
			($stable(q.count) && $stable(rptr))
	) else $error("refused read changed state");
	a_ram_read: assert property (
		(!q.fifo_en && rd_en_i && !ctrl_wr) |=> rd_valid_o
	) else $error("read port gave no data");
	a_ctrl_clears: assert property (
		ctrl_wr |=> (wptr == 12'h000 && rptr == 12'h000 && q.count == 13'h0000)
	) else $error("control write left pointers or occupancy");

	c_reach_full: cover property (q.fifo_en && full_o);
	c_full_to_empty: cover property (full_o ##[1:1000] empty_o);
	c_narrow_read: cover property (q.fifo_en && q.wwid == esf_pkg::W4 && q.rwid == esf_pkg::W1 && rd_ok);
	c_irq_raised: cover property ($rose(irq_o));
	c_preload_fifo: cover property (q.fifo_en && tst_we_i);
endmodule

// ---- esf_fab.sv ----
// Fabric-side user logic model that drives the write and read ports of the block.
`timescale 1ns/1ps
module esf_fab (
	// Clock
	input wire logic mclk_i,
	// Write port
	output logic wr_en_o,
	output logic [11:0] wr_addr_o,
	output logic [17:0] wr_data_o,
	// Read port
	output logic rd_en_o,
	output logic [11:0] rd_addr_o,
	input wire logic [17:0] rd_data_i,
	input wire logic rd_valid_i
);
	initial begin
		wr_en_o = 1'b0;
		wr_addr_o = 12'h000;
		wr_data_o = 18'h00000;
		rd_en_o = 1'b0;
		rd_addr_o = 12'h000;
	end

	task automatic push(input logic [11:0] a, input logic [17:0] d);
		begin
			@(posedge mclk_i);
			wr_en_o <= 1'b1;
			wr_addr_o <= a;
			wr_data_o <= d;
			@(posedge mclk_i);
			wr_en_o <= 1'b0;
			// Released data shows its inverse so a late sample cannot match by luck.
			wr_data_o <= ~d;
		end
	endtask

	task automatic pop(input logic [11:0] a, output logic [17:0] d, output logic got);
		int n;
		begin
			@(posedge mclk_i);
			rd_en_o <= 1'b1;
			rd_addr_o <= a;
			@(posedge mclk_i);
			rd_en_o <= 1'b0;
			rd_addr_o <= ~a;
			n = 0;
			got = 1'b0;
			d = 18'h00000;
			while (n < 3 && got !== 1'b1) begin
				@(posedge mclk_i);
				got = rd_valid_i;
				d = rd_data_i;
				n++;
			end
		end
	endtask
endmodule

// ---- esf_top_test.sv ----
// Self-checking bench for the memory block: registers, FIFO flags, width change, preload.
`timescale 1ns/1ps
`include "esf_cfg.svh"
module esf_top_test;
	logic mclk_i = 1'b0;
	logic reset_i = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic tst_we = 1'b0;
	logic [7:0] tst_addr = 8'h00;
	logic [17:0] tst_data = 18'h00000;
	logic [31:0] hrdata;
	logic hreadyout, hresp, wr_en, rd_en, rd_valid, empty, full, nd, nf, irq;
	logic [11:0] wr_addr;
	logic [11:0] rd_addr;
	logic [17:0] wr_data;
	logic [17:0] rd_data;
	logic [4:0] pins;
	int miscompares = 0;
	int checked = 0;
	localparam logic [4:0] fill_flags [0:3] = '{5'h04, 5'h00, 5'h08, 5'h0a};
	localparam logic [4:0] drain_flags [0:3] = '{5'h08, 5'h00, 5'h04, 5'h15};

	assign pins = {irq, nf, nd, full, empty};
	always #12.5 mclk_i = ~mclk_i;

	esf_top i_dut (
		.mclk_i(mclk_i), .reset_i(reset_i),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
		.hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
		.wr_en_i(wr_en), .wr_addr_i(wr_addr), .wr_data_i(wr_data),
		.rd_en_i(rd_en), .rd_addr_i(rd_addr), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
		.empty_o(empty), .full_o(full),
		.nearly_drained_flag_o(nd), .nearly_filled_flag_o(nf),
		.tst_we_i(tst_we), .tst_addr_i(tst_addr), .tst_data_i(tst_data),
		.irq_o(irq)
	);

	esf_fab i_fab (
		.mclk_i(mclk_i),
		.wr_en_o(wr_en), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
		.rd_en_o(rd_en), .rd_addr_o(rd_addr), .rd_data_i(rd_data), .rd_valid_i(rd_valid)
	);

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		begin
			checked++;
			if (got !== exp) begin
				miscompares++;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask

	// Flags and interrupt are registered, so let the update edges land first.
	task automatic cmp_pins(input logic [4:0] exp);
		begin
			repeat (2) @(negedge mclk_i);
			cmp_word({27'h0, pins}, {27'h0, exp});
		end
	endtask

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rv);
		begin
			@(posedge mclk_i);
			hsel <= 1'b1;
			htrans <= 2'h2;
			hwrite <= wr;
			haddr <= {24'h000000, a};
			@(posedge mclk_i);
			while (hreadyout !== 1'b1) @(posedge mclk_i);
			hsel <= 1'b0;
			htrans <= 2'h0;
			hwdata <= wd;
			@(posedge mclk_i);
			while (hreadyout !== 1'b1) @(posedge mclk_i);
			rv = hrdata;
		end
	endtask

	task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		begin
			ahb(1'b1, a, d, v);
		end
	endtask

	task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		begin
			ahb(1'b0, a, 32'h00000000, v);
			cmp_word(v, e);
		end
	endtask

	task automatic print_verdict();
		begin
			$display("checked %0d miscompares %0d", checked, miscompares);
			if (miscompares == 0 && checked > 0) begin
				$display("DONE - PASS");
			end else begin
				$display("DONE - FAIL");
			end
			$finish;
		end
	endtask

	initial begin
		repeat (20000) @(posedge mclk_i);
		miscompares++;
		print_verdict();
	end

	initial begin
		logic [17:0] d;
		logic g;
		repeat (10) @(posedge mclk_i);
		reset_i <= 1'b0;
		chk_reg(`ESF_OFF_CTRL, 32'h00000000);
		chk_reg(`ESF_OFF_DEPTH, 32'h00001200);
		chk_reg(`ESF_OFF_AE_THR, 32'h00000000);
		chk_reg(`ESF_OFF_AF_THR, 32'h00001200);
		chk_reg(`ESF_OFF_STATUS, 32'h00000001);
		chk_reg(`ESF_OFF_IRQ_EN, 32'h00000000);
		ahb_wr(8'h20, 32'hffffffff);
		chk_reg(8'h20, 32'h00000000);
		cmp_word({31'h0, hresp}, 32'h00000000);
		cmp_word({31'h0, hreadyout}, 32'h00000001);
		$display("test reset values done");
		// A 512-word by 9 shape must hold the full 4608 bits.
		ahb_wr(`ESF_OFF_CTRL, 32'h0000005b);
		for (int i = 0; i < 513; i++) i_fab.push(12'h000, {9'h000, 9'(i) ^ 9'h155});
		cmp_pins(5'h0a);
		chk_reg(`ESF_OFF_STATUS, 32'h1200000a);
		chk_reg(`ESF_OFF_IRQ_STS, 32'h00000005);
		for (int i = 0; i < 512; i++) begin
			i_fab.pop(12'h000, d, g);
			cmp_word({14'h0, d}, {23'h0, 9'(i) ^ 9'h155});
		end
		cmp_pins(5'h05);
		i_fab.pop(12'h000, d, g);
		cmp_word({31'h0, g}, 32'h00000000);
		chk_reg(`ESF_OFF_IRQ_STS, 32'h0000000f);
		$display("test full capacity done");
		ahb_wr(`ESF_OFF_IRQ_EN, 32'h00000003);
		cmp_pins(5'h15);
		ahb_wr(`ESF_OFF_IRQ_CLR, 32'h00000003);
		cmp_pins(5'h05);
		chk_reg(`ESF_OFF_IRQ_STS, 32'h0000000c);
		ahb_wr(`ESF_OFF_IRQ_EN, 32'h00000008);
		cmp_pins(5'h15);
		ahb_wr(`ESF_OFF_IRQ_CLR, 32'h0000000f);
		cmp_pins(5'h05);
		$display("test interrupt done");
		// Four 18-bit words of depth, thresholds one word from either end.
		ahb_wr(`ESF_OFF_DEPTH, 32'h00000048);
		ahb_wr(`ESF_OFF_AE_THR, 32'h00000012);
		ahb_wr(`ESF_OFF_AF_THR, 32'h00000036);
		ahb_wr(`ESF_OFF_CTRL, 32'h00000064);
		chk_reg(`ESF_OFF_DEPTH, 32'h00000048);
		cmp_pins(5'h05);
		for (int i = 0; i < 4; i++) begin
			i_fab.push(12'h000, 18'h3c000 | 18'(i));
			cmp_pins(fill_flags[i]);
		end
		i_fab.push(12'h000, 18'h00000);
		chk_reg(`ESF_OFF_STATUS, 32'h0048000a);
		for (int i = 0; i < 4; i++) begin
			i_fab.pop(12'h000, d, g);
			cmp_word({14'h0, d}, {14'h0, 18'h3c000 | 18'(i)});
			cmp_word({31'h0, g}, 32'h00000001);
			cmp_pins(drain_flags[i]);
		end
		$display("test depth and thresholds done");
		// Four bits written at once come back one at a time, low bit first.
		ahb_wr(`ESF_OFF_IRQ_CLR, 32'h0000000f);
		ahb_wr(`ESF_OFF_CTRL, 32'h00000042);
		i_fab.push(12'h000, 18'h0000a);
		chk_reg(`ESF_OFF_STATUS, 32'h00040004);
		for (int i = 0; i < 4; i++) begin
			i_fab.pop(12'h000, d, g);
			cmp_word({31'h0, d[0]}, {31'h0, 1'(4'ha >> i)});
		end
		$display("test width change done");
		// Preload while the FIFO runs: the word lands, the occupancy must not move.
		@(posedge mclk_i);
		tst_we <= 1'b1;
		tst_addr <= 8'h05;
		tst_data <= 18'h2abcd;
		@(posedge mclk_i);
		tst_we <= 1'b0;
		tst_data <= 18'h15432;
		chk_reg(`ESF_OFF_STATUS, 32'h00000005);
		// Width codes above the widest shape fall back to 18 bits.
		ahb_wr(`ESF_OFF_CTRL, 32'h0000003f);
		chk_reg(`ESF_OFF_CTRL, 32'h00000024);
		i_fab.pop(12'h005, d, g);
		cmp_word({14'h0, d}, 32'h0002abcd);
		cmp_word({31'h0, g}, 32'h00000001);
		i_fab.push(12'h009, 18'h1f0f0);
		i_fab.pop(12'h009, d, g);
		cmp_word({14'h0, d}, 32'h0001f0f0);
		ahb_wr(`ESF_OFF_CTRL, 32'h00000009);
		i_fab.push(12'h003, 18'h00002);
		i_fab.pop(12'h003, d, g);
		cmp_word({14'h0, d}, 32'h00000002);
		$display("test preload and ram done");
		print_verdict();
	end
endmodule
